/* core/pgio_pkg.sv */
package pgio_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_LEVELS   = 16'h5200;
  localparam logic [15:0] OFS_OUTVAL   = 16'h5201;
  localparam logic [15:0] OFS_DRIVE    = 16'h5202;
  localparam logic [15:0] OFS_PULLUP   = 16'h5203;
  localparam logic [15:0] OFS_IRQ_EN   = 16'h5205;
  localparam logic [15:0] OFS_EDGE_POL = 16'h5206;
  localparam logic [15:0] OFS_FLAGS    = 16'h5207;
  localparam logic [15:0] OFS_DEBOUNCE = 16'h5208;

  // ----------------------------------------------------------------
  // reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_OUTVAL   = 8'h00;
  localparam logic [7:0] RST_DRIVE    = 8'h00;
  localparam logic [7:0] RST_PULLUP   = 8'hff;
  localparam logic [7:0] RST_IRQ_EN   = 8'h00;
  localparam logic [7:0] RST_EDGE_POL = 8'h00;
  localparam logic [7:0] RST_FLAGS    = 8'h00;
  localparam logic [2:0] RST_DEB_CODE = 3'h0;
  localparam int         DEB_LO_POS   = 0;
  localparam int         DEB_HI_POS   = 4;

  // ----------------------------------------------------------------
  // filter timing, in peripheral clock periods
  // ----------------------------------------------------------------
  localparam int          DEB_BASE_PERIODS = 256;
  localparam int          DEB_CNT_W        = 15;
  localparam logic [2:0]  DEB_CODE_OFF     = 3'h0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } pgio_req_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
  } pgio_pad_t;

endpackage

/* core/pgio_port.sv */
// Functional notes
// - read-only byte returns current level of each pin, 1 high
// - eight-bit output value register, reset zero, 1 drives high
// - per-pin drive enable, reset zero; pin driven only when set
// - per-pin pull-up enable, resets to all ones
// - per-pin interrupt enable, reset zero, lets flag request interrupt
// - per-pin edge polarity, reset zero; 1 falling, 0 rising
// - flag set on selected edge; write one clears, zero keeps
// - pins 7..4 filter, code 0 off, 1..7 give 256..16384 clocks
// - pins 3..0 independent filter, same codes, reset to off
module pgio_port #(
  parameter int DEB_BASE = pgio_pkg::DEB_BASE_PERIODS
) (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst_b,
  // register port
  input  wire pgio_pkg::pgio_req_t req,
  output logic [7:0]              rdata,
  // pads
  input  wire logic [7:0]         pad_in,
  output pgio_pkg::pgio_pad_t     pad,
  // interrupt
  output logic                    irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  // filter counter width
  localparam int DEB_CNT_W = pgio_pkg::DEB_CNT_W;

  logic [7:0]           pin_out_bits;
  logic [7:0]           pin_drive_enable_bits;
  logic [7:0]           pin_pullup_bits;
  logic [7:0]           pin_irq_enable_bits;
  logic [7:0]           pin_edge_select_bits;
  logic [7:0]           pin_irq_flag_bits;
  logic [2:0]           upper_nibble_debounce_code;
  logic [2:0]           lower_nibble_debounce_code;
  logic [7:0]           sync1;
  logic [7:0]           pin_level_bits;
  logic [7:0]           raw_last;
  logic [7:0]           filt;
  logic [7:0]           filt_prev;
  logic [DEB_CNT_W-1:0] cnt_lo;
  logic [DEB_CNT_W-1:0] cnt_hi;
  logic [7:0]           next_rdata;
  logic [7:0]           next_flags;
  logic [7:0]           next_filt;
  logic [DEB_CNT_W-1:0] next_cnt_lo;
  logic [DEB_CNT_W-1:0] next_cnt_hi;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // last count of a filter window for a code
  function automatic logic [DEB_CNT_W-1:0] deb_last(input logic [2:0] code);
    logic [DEB_CNT_W:0] span;
    span = (DEB_CNT_W+1)'(DEB_BASE) << (code - 3'h1);
    return DEB_CNT_W'(span - (DEB_CNT_W+1)'(1));
  endfunction

  // one nibble counter step: restart on change, hold at window end
  function automatic logic [DEB_CNT_W-1:0] deb_step(
    input logic [DEB_CNT_W-1:0] cnt,
    input logic                 moved,
    input logic [2:0]           code
  );
    logic [DEB_CNT_W-1:0] nxt;
    nxt = cnt;
    if (moved || code == pgio_pkg::DEB_CODE_OFF) begin
      nxt = '0;
    end else if (cnt != deb_last(code)) begin
      nxt = cnt + DEB_CNT_W'(1);
    end
    return nxt;
  endfunction

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // register selects
  wire sel_levels = req.addr == pgio_pkg::OFS_LEVELS;
  wire sel_outval = req.addr == pgio_pkg::OFS_OUTVAL;
  wire sel_drive  = req.addr == pgio_pkg::OFS_DRIVE;
  wire sel_pullup = req.addr == pgio_pkg::OFS_PULLUP;
  wire sel_irq_en = req.addr == pgio_pkg::OFS_IRQ_EN;
  wire sel_edge   = req.addr == pgio_pkg::OFS_EDGE_POL;
  wire sel_flags  = req.addr == pgio_pkg::OFS_FLAGS;
  wire sel_deb    = req.addr == pgio_pkg::OFS_DEBOUNCE;

  // write strobes per register
  wire wr_outval = req.wr && sel_outval;
  wire wr_drive  = req.wr && sel_drive;
  wire wr_pullup = req.wr && sel_pullup;
  wire wr_irq_en = req.wr && sel_irq_en;
  wire wr_edge   = req.wr && sel_edge;
  wire wr_deb    = req.wr && sel_deb;

  // filter code register image, reserved bits read zero
  wire [7:0] deb_reg = {1'b0, upper_nibble_debounce_code,
                        1'b0, lower_nibble_debounce_code};

  // read mux, unmapped reads zero
  always_comb begin
    next_rdata = 8'h00;
    if (req.rd) begin
      unique case (1'b1)
        sel_levels: next_rdata = pin_level_bits;
        sel_outval: next_rdata = pin_out_bits;
        sel_drive:  next_rdata = pin_drive_enable_bits;
        sel_pullup: next_rdata = pin_pullup_bits;
        sel_irq_en: next_rdata = pin_irq_enable_bits;
        sel_edge:   next_rdata = pin_edge_select_bits;
        sel_flags:  next_rdata = pin_irq_flag_bits;
        sel_deb:    next_rdata = deb_reg;
        default:    next_rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin input path
  // ----------------------------------------------------------------
  // first synchroniser stage, reset to the pulled-up idle level
  // so idle-high pins show no false rising edge after reset
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= pgio_pkg::RST_PULLUP;
    end else begin
      sync1 <= pad_in;
    end
  end

  // second synchroniser stage, the only reader of the first
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_level_bits <= pgio_pkg::RST_PULLUP;
    end else begin
      pin_level_bits <= sync1;
    end
  end

  // level change seen within each nibble
  wire moved_lo = raw_last[3:0] != pin_level_bits[3:0];
  wire moved_hi = raw_last[7:4] != pin_level_bits[7:4];

  // filter off and window end per nibble
  wire off_lo   = lower_nibble_debounce_code == pgio_pkg::DEB_CODE_OFF;
  wire off_hi   = upper_nibble_debounce_code == pgio_pkg::DEB_CODE_OFF;
  wire done_lo  = cnt_lo == deb_last(lower_nibble_debounce_code);
  wire done_hi  = cnt_hi == deb_last(upper_nibble_debounce_code);

  // counter steps per nibble
  assign next_cnt_lo = deb_step(cnt_lo, moved_lo,
                                lower_nibble_debounce_code);
  assign next_cnt_hi = deb_step(cnt_hi, moved_hi,
                                upper_nibble_debounce_code);

  // filtered level: bypass when off, else accept after a quiet window
  always_comb begin
    next_filt = filt;
    if (off_lo || (done_lo && !moved_lo)) begin
      next_filt[3:0] = pin_level_bits[3:0];
    end
    if (off_hi || (done_hi && !moved_hi)) begin
      next_filt[7:4] = pin_level_bits[7:4];
    end
  end

  // nibble quiet-time counters
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_lo <= '0;
      cnt_hi <= '0;
    end else begin
      cnt_lo <= next_cnt_lo;
      cnt_hi <= next_cnt_hi;
    end
  end

  // level history, reset to the same idle level as the synchroniser
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      raw_last  <= pgio_pkg::RST_PULLUP;
      filt      <= pgio_pkg::RST_PULLUP;
      filt_prev <= pgio_pkg::RST_PULLUP;
    end else begin
      raw_last  <= pin_level_bits;
      filt      <= next_filt;
      filt_prev <= filt;
    end
  end

  // ----------------------------------------------------------------
  // edge detection and flags
  // ----------------------------------------------------------------
  // edges of the filtered level
  wire [7:0] rise = filt & ~filt_prev;
  wire [7:0] fall = ~filt & filt_prev;
  wire [7:0] edge_hit = (pin_edge_select_bits & fall)
                      | (~pin_edge_select_bits & rise);
  wire       flag_wr  = req.wr && sel_flags;

  // write one clears, a new edge in the same cycle wins
  always_comb begin
    next_flags = pin_irq_flag_bits;
    if (flag_wr) begin
      next_flags = pin_irq_flag_bits & ~req.wdata;
    end
    next_flags = next_flags | edge_hit;
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // output values
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_out_bits <= pgio_pkg::RST_OUTVAL;
    end else if (wr_outval) begin
      pin_out_bits <= req.wdata;
    end
  end

  // drive enables
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_drive_enable_bits <= pgio_pkg::RST_DRIVE;
    end else if (wr_drive) begin
      pin_drive_enable_bits <= req.wdata;
    end
  end

  // pull-up enables
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_pullup_bits <= pgio_pkg::RST_PULLUP;
    end else if (wr_pullup) begin
      pin_pullup_bits <= req.wdata;
    end
  end

  // interrupt enables
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_irq_enable_bits <= pgio_pkg::RST_IRQ_EN;
    end else if (wr_irq_en) begin
      pin_irq_enable_bits <= req.wdata;
    end
  end

  // edge polarity
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_edge_select_bits <= pgio_pkg::RST_EDGE_POL;
    end else if (wr_edge) begin
      pin_edge_select_bits <= req.wdata;
    end
  end

  // filter codes, reserved bits 7 and 3 dropped
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      upper_nibble_debounce_code <= pgio_pkg::RST_DEB_CODE;
      lower_nibble_debounce_code <= pgio_pkg::RST_DEB_CODE;
    end else if (wr_deb) begin
      upper_nibble_debounce_code <= req.wdata[pgio_pkg::DEB_HI_POS +: 3];
      lower_nibble_debounce_code <= req.wdata[pgio_pkg::DEB_LO_POS +: 3];
    end
  end

  // interrupt flags
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_irq_flag_bits <= pgio_pkg::RST_FLAGS;
    end else begin
      pin_irq_flag_bits <= next_flags;
    end
  end

  // read data, one cycle after the read strobe
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // pad controls straight from their registers
  assign pad = '{out: pin_out_bits,
                 oe:  pin_drive_enable_bits,
                 pu:  pin_pullup_bits};
  assign irq     = |(pin_irq_flag_bits & pin_irq_enable_bits);

endmodule // pgio_port

/* tb/pgio_port_chk.sv */
module pgio_port_chk (
  // clock and reset
  input wire logic                ref_clk,
  input wire logic                rst_b,
  // register port, pads, interrupt
  input wire pgio_pkg::pgio_req_t req,
  input wire logic [7:0]          rdata,
  input wire logic [7:0]          pad_in,
  input wire pgio_pkg::pgio_pad_t pad,
  input wire logic                irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [7:0] en_copy;
  // write and read decodes
  wire w_out = req.wr && req.addr == 16'h5201;
  wire w_oe  = req.wr && req.addr == 16'h5202;
  wire w_pu  = req.wr && req.addr == 16'h5203;
  wire w_en  = req.wr && req.addr == 16'h5205;
  wire r_lvl = req.rd && req.addr == 16'h5200;
  // copy of the interrupt enables
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) en_copy <= 8'h00;
    else if (w_en) en_copy <= req.wdata;
  end
  property p_rst; $rose(rst_b) |-> pad == 24'h0000ff && !irq; endproperty
  a_rst: assert property (p_rst) else $error("pads not at reset values");
  property p_out; w_out |=> pad.out == $past(req.wdata); endproperty
  a_out: assert property (p_out) else $error("output value not loaded");
  property p_oe; w_oe |=> pad.oe == $past(req.wdata); endproperty
  a_oe: assert property (p_oe) else $error("drive enable not loaded");
  property p_pu; w_pu |=> pad.pu == $past(req.wdata); endproperty
  a_pu: assert property (p_pu) else $error("pull-up not loaded");
  property p_hold; !(w_out || w_oe || w_pu) |=> $stable(pad); endproperty
  a_hold: assert property (p_hold) else $error("pads moved without write");
  property p_lvl; r_lvl && $stable(pad_in) && pad_in == $past(pad_in, 2) && $past(rst_b, 3)
    |=> rdata == $past(pad_in); endproperty
  a_lvl: assert property (p_lvl) else $error("level read wrong");
  property p_msk; en_copy == 8'h00 |-> !irq; endproperty
  a_msk: assert property (p_msk) else $error("irq with all enables off");
  property p_rsv; req.rd && req.addr == 16'h5208 |=> !rdata[7] && !rdata[3]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved filter bits set");
  property p_idle; !req.rd |=> rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read");
  // main scenarios
  cover property (irq ##1 !irq);
  cover property (r_lvl);
  cover property (req.rd && req.addr == 16'h5207 ##1 rdata != 8'h00);
endmodule // pgio_port_chk

bind pgio_port pgio_port_chk u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .req(req),
  .rdata(rdata), .pad_in(pad_in), .pad(pad), .irq(irq));

/* tb/pgio_pads.sv */
module pgio_pads (
  // clock
  input wire logic                ref_clk,
  // pad controls and far-side drive
  input wire pgio_pkg::pgio_pad_t pad,
  input wire logic [7:0]          ext_drv,
  input wire logic [7:0]          ext_en,
  // resolved pin levels
  output logic [7:0]              pin_lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last = 8'h00;
  // port drive, then outside source, then pull-up, else floating
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad.oe[i]) pin_lvl[i] = pad.out[i];
      else if (ext_en[i]) pin_lvl[i] = ext_drv[i];
      else if (pad.pu[i]) pin_lvl[i] = 1'b1;
      else pin_lvl[i] = ~last[i];
    end
  end
  // floating pins toggle every cycle
  always_ff @(posedge ref_clk) last <= pin_lvl;
endmodule // pgio_pads

/* tb/pgio_port_bench.sv */
module pgio_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [15:0] a; logic [7:0] d, r, e;} pgio_row_t;
  logic                ref_clk = 1'b0;
  logic                rst_b   = 1'b0;
  pgio_pkg::pgio_req_t req     = '0;
  logic [7:0]          rdata, pad_in, v;
  logic [7:0]          ext_drv = 8'h81;
  logic [7:0]          ext_en  = 8'hc3;
  pgio_pkg::pgio_pad_t pad;
  logic                irq;
  int                  fails = 0;
  int                  cmp_count = 0;
  // address, write, value before write, value after write
  pgio_row_t rows [9] = '{'{16'h5200, 8'h00, 8'hbd, 8'hbd}, '{16'h5201, 8'ha5, 8'h00, 8'ha5},
    '{16'h5202, 8'h3c, 8'h00, 8'h3c}, '{16'h5203, 8'h0f, 8'hff, 8'h0f},
    '{16'h5205, 8'h5a, 8'h00, 8'h5a}, '{16'h5206, 8'ha5, 8'h00, 8'ha5},
    '{16'h5207, 8'hff, 8'h00, 8'h00}, '{16'h5208, 8'hff, 8'h00, 8'h77},
    '{16'h5204, 8'hff, 8'h00, 8'h00}};
  always #20 ref_clk = ~ref_clk;
  pgio_port #(.DEB_BASE(4)) dut (.ref_clk(ref_clk), .rst_b(rst_b), .req(req),
    .rdata(rdata), .pad_in(pad_in), .pad(pad), .irq(irq));
  pgio_pads pads (.ref_clk(ref_clk), .pad(pad), .ext_drv(ext_drv), .ext_en(ext_en),
    .pin_lvl(pad_in));
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  // one-cycle register write, settled after the taking edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk) req <= '{a, d, 1'b0, 1'b0};
    #1;
  endtask
  // one-cycle register read, data taken in the following cycle
  task automatic rd(input logic [15:0] a);
    @(posedge ref_clk) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk) req <= '{a, 8'h00, 1'b0, 1'b0};
    #1 v = rdata;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    chk(pad.pu, 8'hff);
    chk(pad.out | pad.oe, 8'h00);
    chk({7'h00, irq}, 8'h00);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    foreach (rows[i]) begin
      rd(rows[i].a);
      chk(v, rows[i].r);
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(v, rows[i].e);
    end
    $display("register table done");
    chk(pad.out, 8'ha5);
    chk(pad.oe, 8'h3c);
    chk(pad.pu, 8'h0f);
    rd(16'h5200);
    chk(v, (8'ha5 & 8'h3c) | (ext_drv & ext_en));
    wr(16'h5208, 8'h00);
    wr(16'h5206, 8'h02);
    wr(16'h5205, 8'h03);
    repeat (8) @(posedge ref_clk);
    wr(16'h5207, 8'hff);
    for (int s = 0; s < 3; s++) begin
      @(posedge ref_clk) ext_drv[1:0] <= (s == 1) ? 2'b11 : 2'b00;
      repeat (8) @(posedge ref_clk);
      rd(16'h5207);
      chk(v, (s == 0) ? 8'h00 : (s == 1) ? 8'h01 : 8'h03);
    end
    chk({7'h00, irq}, 8'h01);
    wr(16'h5205, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr(16'h5205, 8'h03);
    wr(16'h5207, 8'h00);
    rd(16'h5207);
    chk(v, 8'h03);
    wr(16'h5207, 8'h01);
    rd(16'h5207);
    chk(v, 8'h02);
    chk({7'h00, irq}, 8'h01);
    wr(16'h5207, 8'h02);
    chk({7'h00, irq}, 8'h00);
    $display("edge interrupt done");
    wr(16'h5206, 8'h00);
    wr(16'h5205, 8'h81);
    for (int n = 0; n < 2; n++) begin
      wr(16'h5208, n ? 8'h30 : 8'h03);
      @(posedge ref_clk) ext_drv <= ext_drv & 8'h7e;
      repeat (40) @(posedge ref_clk);
      wr(16'h5207, 8'hff);
      @(posedge ref_clk) ext_drv <= ext_drv | 8'h81;
      repeat (8) @(posedge ref_clk);
      rd(16'h5207);
      chk(v, n ? 8'h01 : 8'h80);
      repeat (30) @(posedge ref_clk);
      rd(16'h5207);
      chk(v, 8'h81);
    end
    $display("chatter filter done");
    stop_test();
  end
  // watchdog
  initial begin
    #50us;
    fails++;
    stop_test();
  end
endmodule // pgio_port_bench
